// [rtl/instr_exec.sv]
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
// Summary of operation
// - watchdog clear instruction zeroes the watchdog counter in one cycle
// - the same instruction also zeroes the watchdog postscaler
// - it sets timeout and power-down flags, touching no other flag
// - complement inverts the addressed byte, updating only negative and zero
// - destination bit zero: result goes to working register, byte kept
// - destination bit one: result written back to the addressed byte
// - access bit zero: address resolves inside the access bank
// - access bit one: bank select register supplies the upper address
// - extended set, access zero, address up to 5Fh: indexed offset
module instr_exec import exec_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic timeout_flag,
	output logic power_down_flag,
	output logic [7:0] watchdog_counter
);
	state_t s_reg;
	state_t s_next;
	logic mem_we;
	logic [11:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic core_we;
	logic bus_mem_wr;

	ram_if ram ();

	file_ram u_ram (
		.clk(clk),
		.port(ram.mem)
	);

	// opcode decode, used by the pipeline and the checks
	function automatic logic is_complement(input logic [15:0] instr);
		return instr[15:10] == OP_COMPLEMENT;
	endfunction

	function automatic logic is_wdt_clear(input logic [15:0] instr);
		return instr == OP_WDT_CLEAR;
	endfunction

	// effective file address from the low byte and access bit
	function automatic logic [11:0] resolve_addr(
		input logic [7:0] f,
		input logic acc,
		input logic ext,
		input logic [3:0] bank_select_reg,
		input logic [11:0] fsr2
	);
		logic [11:0] a;
		a = {ACCESS_LO_BANK, f};
		if (acc) begin
			a = {bank_select_reg, f};
		end else if (ext && f <= INDEX_LIMIT) begin
			a = fsr2 + {4'h0, f};
		end else if (f <= INDEX_LIMIT) begin
			a = {ACCESS_LO_BANK, f};
		end else begin
			a = {ACCESS_HI_BANK, f};
		end
		return a;
	endfunction

	// memory wiring; reads of the core happen from the latched address
	assign ram.core_addr = s_reg.ea;
	assign ram.bus_addr = s_reg.mem_addr;
	assign ram.we = mem_we;
	assign ram.waddr = mem_waddr;
	assign ram.wdata = mem_wdata;

	// outputs come straight from the state register
	assign reg_rdata = s_reg.rdata;
	assign timeout_flag = s_reg.to;
	assign power_down_flag = s_reg.pd;
	assign watchdog_counter = s_reg.wdt;

	assign bus_mem_wr = reg_wr && (reg_addr == REG_MEM_DATA);

	always_comb begin
		s_next = s_reg;
		core_we = 1'b0;
		mem_we = 1'b0;
		mem_waddr = s_reg.bus_waddr;
		mem_wdata = s_reg.bus_wdata;

		// four phases per instruction cycle
		case (s_reg.phase)
			PH_Q1: s_next.phase = PH_Q2;
			PH_Q2: s_next.phase = PH_Q3;
			PH_Q3: s_next.phase = PH_Q4;
			PH_Q4: s_next.phase = PH_Q1;
			default: s_next.phase = PH_Q1;
		endcase

		// q1: take the pending instruction and resolve its address
		if (s_reg.phase == PH_Q1) begin
			s_next.valid = s_reg.pend;
			if (s_reg.pend) begin
				s_next.ir = s_reg.pend_instr;
				s_next.pend = 1'b0;
				s_next.ea = resolve_addr(s_reg.pend_instr[7:0],
					s_reg.pend_instr[ACC_BIT], s_reg.ext_en,
					s_reg.bank_select_reg, s_reg.fsr2);
			end
		end

		// free-running watchdog, ticked once per instruction cycle
		if (s_reg.phase == PH_Q4) begin
			if (s_reg.wdt == WDT_MAX) begin
				s_next.wdt = WDT_CLEAR;
				if (s_reg.post == POST_MAX) begin
					s_next.post = POST_CLEAR;
					s_next.to = 1'b0; // expiry drops timeout flag
				end else begin
					s_next.post = s_reg.post + 4'h1;
				end
			end else begin
				s_next.wdt = s_reg.wdt + 8'h01;
			end
		end

		// software writes; hardware updates below take precedence
		if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: s_next.ext_en = reg_wdata[CTRL_EXT_BIT];
				REG_INSTR: begin
					s_next.pend = 1'b1;
					s_next.pend_instr = reg_wdata;
				end
				REG_BSR: s_next.bank_select_reg = reg_wdata[3:0];
				REG_WREG: s_next.wreg = reg_wdata[7:0];
				REG_STATUS: begin
					s_next.zero = reg_wdata[STATUS_Z_BIT];
					s_next.neg = reg_wdata[STATUS_N_BIT];
					s_next.pd = reg_wdata[STATUS_PD_BIT];
					s_next.to = reg_wdata[STATUS_TO_BIT];
				end
				REG_FSR2: s_next.fsr2 = reg_wdata[11:0];
				REG_MEM_ADDR: s_next.mem_addr = reg_wdata[11:0];
				default: s_next.pend = s_next.pend;
			endcase
		end

		// read data stand for exactly one cycle
		s_next.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: begin
					s_next.rdata[CTRL_EXT_BIT] = s_reg.ext_en;
					s_next.rdata[CTRL_BUSY_BIT] = s_reg.pend;
				end
				REG_INSTR: s_next.rdata = s_reg.ir;
				REG_BSR: s_next.rdata = {12'h000, s_reg.bank_select_reg};
				REG_WREG: s_next.rdata = {8'h00, s_reg.wreg};
				REG_STATUS: begin
					s_next.rdata[STATUS_Z_BIT] = s_reg.zero;
					s_next.rdata[STATUS_N_BIT] = s_reg.neg;
					s_next.rdata[STATUS_PD_BIT] = s_reg.pd;
					s_next.rdata[STATUS_TO_BIT] = s_reg.to;
				end
				REG_WDT: s_next.rdata = {8'h00, s_reg.wdt};
				REG_POST: s_next.rdata = {12'h000, s_reg.post};
				REG_FSR2: s_next.rdata = {4'h0, s_reg.fsr2};
				REG_MEM_ADDR: s_next.rdata = {4'h0, s_reg.mem_addr};
				REG_MEM_DATA: s_next.rdata = {8'h00, ram.bus_q};
				default: s_next.rdata = 16'h0000;
			endcase
		end

		// q3: process data; set beats a same-cycle software clear
		if (s_reg.phase == PH_Q3 && s_reg.valid) begin
			if (is_complement(s_reg.ir)) begin
				s_next.result = ~ram.core_q;
				s_next.neg = ~ram.core_q[7];
				s_next.zero = (ram.core_q == 8'hFF);
			end else if (is_wdt_clear(s_reg.ir)) begin
				s_next.wdt = WDT_CLEAR;
				s_next.post = POST_CLEAR;
				s_next.to = FLAG_SET;
				s_next.pd = FLAG_SET;
			end
		end

		// q4: write the destination
		if (s_reg.phase == PH_Q4 && s_reg.valid &&
			is_complement(s_reg.ir)) begin
			if (s_reg.ir[DEST_BIT]) begin
				core_we = 1'b1;
			end else begin
				s_next.wreg = s_reg.result;
			end
		end

		// one write port: the core wins, a bus write waits one slot
		if (core_we) begin
			mem_we = 1'b1;
			mem_waddr = s_reg.ea;
			mem_wdata = s_reg.result;
			if (bus_mem_wr) begin
				s_next.bus_wpend = 1'b1;
				s_next.bus_waddr = s_reg.mem_addr;
				s_next.bus_wdata = reg_wdata[7:0];
			end
		end else if (s_reg.bus_wpend) begin
			mem_we = 1'b1;
			s_next.bus_wpend = bus_mem_wr;
			if (bus_mem_wr) begin
				s_next.bus_waddr = s_reg.mem_addr;
				s_next.bus_wdata = reg_wdata[7:0];
			end
		end else if (bus_mem_wr) begin
			mem_we = 1'b1;
			mem_waddr = s_reg.mem_addr;
			mem_wdata = reg_wdata[7:0];
		end
	end

	// whole state registered in one place
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// checks, all on clk and disabled during reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	logic ex_comp;
	logic ex_clear;
	assign ex_comp = s_reg.valid && is_complement(s_reg.ir);
	assign ex_clear = s_reg.valid && is_wdt_clear(s_reg.ir);

	a_clear_zeroes_wdt: assert property (
		s_reg.phase == PH_Q3 && ex_clear |=> s_reg.wdt == WDT_CLEAR)
		else $error("watchdog counter not cleared");

	a_clear_zeroes_post: assert property (
		s_reg.phase == PH_Q3 && ex_clear |=> s_reg.post == POST_CLEAR
			&& s_reg.wdt == WDT_CLEAR)
		else $error("postscaler not cleared with counter");

	a_clear_sets_flags: assert property (
		s_reg.phase == PH_Q3 && ex_clear |=> s_reg.to && s_reg.pd
			&& $stable(s_reg.zero) && $stable(s_reg.neg))
		else $error("clear did not set only timeout and power-down");

	a_comp_result_flags: assert property (
		s_reg.phase == PH_Q3 && ex_comp |=>
			s_reg.result == ~$past(ram.core_q) &&
			s_reg.zero == (s_reg.result == 8'h00) &&
			s_reg.neg == s_reg.result[7])
		else $error("complement result or flags wrong");

	a_dest_to_wreg: assert property (
		s_reg.phase == PH_Q4 && ex_comp && !s_reg.ir[DEST_BIT] |->
			!core_we ##1 s_reg.wreg == $past(s_reg.result))
		else $error("working register destination wrong");

	a_dest_to_file: assert property (
		s_reg.phase == PH_Q4 && ex_comp && s_reg.ir[DEST_BIT] |->
			mem_we && mem_waddr == s_reg.ea &&
			mem_wdata == s_reg.result)
		else $error("file destination write wrong");

	a_access_bank_addr: assert property (
		s_reg.phase == PH_Q1 && s_reg.pend && !s_reg.pend_instr[ACC_BIT]
			&& !(s_reg.ext_en && s_reg.pend_instr[7:0] <= INDEX_LIMIT)
			|=> s_reg.ea[7:0] == s_reg.ir[7:0] && s_reg.ea[11:8] ==
			(s_reg.ir[7:0] <= INDEX_LIMIT ? ACCESS_LO_BANK
			: ACCESS_HI_BANK))
		else $error("access bank address wrong");

	a_bank_select_addr: assert property (
		s_reg.phase == PH_Q1 && s_reg.pend && s_reg.pend_instr[ACC_BIT]
			|=> s_reg.ea == {$past(s_reg.bank_select_reg), s_reg.ir[7:0]})
		else $error("banked address wrong");

	a_indexed_addr: assert property (
		s_reg.phase == PH_Q1 && s_reg.pend && !s_reg.pend_instr[ACC_BIT]
			&& s_reg.ext_en && s_reg.pend_instr[7:0] <= INDEX_LIMIT
			|=> s_reg.ea == $past(s_reg.fsr2) + {4'h0, s_reg.ir[7:0]})
		else $error("indexed literal offset address wrong");

	a_phase_order: assert property (
		!sys_rst && s_reg.phase == PH_Q1 |=> s_reg.phase == PH_Q2 ##1
			s_reg.phase == PH_Q3 ##1 s_reg.phase == PH_Q4)
		else $error("phase sequence broken");

	c_clear_run: cover property (s_reg.phase == PH_Q3 && ex_clear);
	c_comp_wreg: cover property (s_reg.phase == PH_Q4 && ex_comp
		&& !s_reg.ir[DEST_BIT]);
	c_comp_file: cover property (s_reg.phase == PH_Q4 && core_we);
	c_indexed: cover property (s_reg.phase == PH_Q1 && s_reg.pend
		&& s_reg.ext_en && !s_reg.pend_instr[ACC_BIT]);
endmodule

// [rtl/exec_pkg.sv]
package exec_pkg;

	// register port geometry
	localparam int REG_ADDR_W = 4;
	localparam int REG_DATA_W = 16;
	localparam int FILE_ADDR_W = 12;

	// register offsets on the plain register port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_INSTR = 4'h1;
	localparam logic [3:0] REG_BSR = 4'h2;
	localparam logic [3:0] REG_WREG = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_WDT = 4'h5;
	localparam logic [3:0] REG_POST = 4'h6;
	localparam logic [3:0] REG_FSR2 = 4'h7;
	localparam logic [3:0] REG_MEM_ADDR = 4'h8;
	localparam logic [3:0] REG_MEM_DATA = 4'h9;

	// field positions
	localparam int CTRL_EXT_BIT = 0;
	localparam int CTRL_BUSY_BIT = 1;
	localparam int STATUS_Z_BIT = 0;
	localparam int STATUS_N_BIT = 1;
	localparam int STATUS_PD_BIT = 2;
	localparam int STATUS_TO_BIT = 3;
	localparam int DEST_BIT = 9;
	localparam int ACC_BIT = 8;

	// opcodes
	localparam logic [15:0] OP_WDT_CLEAR = 16'h0004;
	localparam logic [5:0] OP_COMPLEMENT = 6'h07;

	// addressing constants
	localparam logic [7:0] INDEX_LIMIT = 8'h5F;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

	// watchdog values
	localparam logic [7:0] WDT_CLEAR = 8'h00;
	localparam logic [7:0] WDT_MAX = 8'hFF;
	localparam logic [3:0] POST_CLEAR = 4'h0;
	localparam logic [3:0] POST_MAX = 4'hF;
	localparam logic FLAG_SET = 1'b1;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} phase_t;

	typedef struct packed {
		phase_t phase;
		logic pend;
		logic [15:0] pend_instr;
		logic valid;
		logic [15:0] ir;
		logic [11:0] ea;
		logic [7:0] result;
		logic ext_en;
		logic [3:0] bank_select_reg;
		logic [7:0] wreg;
		logic zero;
		logic neg;
		logic to;
		logic pd;
		logic [7:0] wdt;
		logic [3:0] post;
		logic [11:0] fsr2;
		logic [11:0] mem_addr;
		logic bus_wpend;
		logic [11:0] bus_waddr;
		logic [7:0] bus_wdata;
		logic [15:0] rdata;
	} state_t;

	// reset image: timeout and power-down flags start set, everything else clear
	localparam state_t STATE_RST = '{
		phase: PH_Q1, pend: 1'b0, pend_instr: 16'h0000, valid: 1'b0,
		ir: 16'h0000, ea: 12'h000, result: 8'h00, ext_en: 1'b0,
		bank_select_reg: 4'h0, wreg: 8'h00, zero: 1'b0, neg: 1'b0, to: 1'b1,
		pd: 1'b1, wdt: 8'h00, post: 4'h0, fsr2: 12'h000,
		mem_addr: 12'h000, bus_wpend: 1'b0, bus_waddr: 12'h000,
		bus_wdata: 8'h00, rdata: 16'h0000
	};

endpackage

// [rtl/ram_if.sv]
`timescale 1ns/10ps
interface ram_if;
	logic [11:0] core_addr;
	logic [11:0] bus_addr;
	logic [11:0] waddr;
	logic [7:0] wdata;
	logic we;
	logic [7:0] core_q;
	logic [7:0] bus_q;

	modport ctrl (
		output core_addr, bus_addr, waddr, wdata, we,
		input core_q, bus_q
	);
	modport mem (
		input core_addr, bus_addr, waddr, wdata, we,
		output core_q, bus_q
	);
endinterface

// [rtl/file_ram.sv]
`timescale 1ns/10ps
module file_ram (
	input wire logic clk,
	ram_if.mem port
);
	logic [7:0] mem [0:4095];

	// one write port, two registered read ports
	always_ff @(posedge clk) begin
		if (port.we) begin
			mem[port.waddr] <= port.wdata;
		end
		port.core_q <= mem[port.core_addr];
		port.bus_q <= mem[port.bus_addr];
	end
endmodule

// [verif/watchdog_clear_and_complement_exec_bench.sv]
`timescale 1ns/10ps
module watchdog_clear_and_complement_exec_bench import exec_pkg::*;;

	// one complement case: addressing inputs beside the expected result
	typedef struct packed {
		logic a;
		logic d;
		logic ext;
		logic [3:0] bank_select_reg;
		logic [11:0] fsr2;
		logic [7:0] f;
		logic [11:0] phys;
		logic [7:0] init;
		logic [7:0] res;
	} row_t;

	logic clk;
	logic sys_rst;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_rdata;
	logic timeout_flag;
	logic power_down_flag;
	logic [7:0] watchdog_counter;
	logic [15:0] rv;
	int n_errors = 0;
	int checks_done = 0;
	int k;

	// bank 3 on row 3 proves the bank is ignored when the access bit is low
	row_t rows [6] = '{
		'{1'b1, 1'b0, 1'b0, 4'h3, 12'h000, 8'h20, 12'h320, 8'h13, 8'hEC},
		'{1'b1, 1'b1, 1'b0, 4'h5, 12'h000, 8'h40, 12'h540, 8'hFF, 8'h00},
		'{1'b0, 1'b1, 1'b0, 4'h3, 12'h000, 8'h10, 12'h010, 8'h80, 8'h7F},
		'{1'b0, 1'b0, 1'b0, 4'h3, 12'h000, 8'h60, 12'hF60, 8'h00, 8'hFF},
		'{1'b0, 1'b1, 1'b1, 4'h7, 12'h200, 8'h5F, 12'h25F, 8'h55, 8'hAA},
		'{1'b0, 1'b1, 1'b1, 4'h7, 12'h200, 8'h60, 12'hF60, 8'h01, 8'hFE}
	};

	instr_exec u_instr_exec (
		.clk(clk),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.timeout_flag(timeout_flag),
		.power_down_flag(power_down_flag),
		.watchdog_counter(watchdog_counter)
	);

	// 20 MHz
	always #25 clk = ~clk;

	// idle edge after each strobe so no signal is assigned twice at one edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
		@(posedge clk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
			input string msg);
		checks_done++;
		if (got !== exp) begin
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
			n_errors++;
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (12) @(posedge clk);
		chk({15'h0000, timeout_flag & power_down_flag}, 16'h0001, "rst flags");
		chk({8'h00, watchdog_counter}, 16'h0000, "rst counter");
		chk(reg_rdata, 16'h0000, "rst rdata");
		sys_rst <= 1'b0;
		@(posedge clk);
		$display("test reset done");
		// status cleared first so any stray touch of timeout or power-down shows
		foreach (rows[i]) begin
			wr(REG_CTRL, {15'h0000, rows[i].ext});
			wr(REG_BSR, {12'h000, rows[i].bank_select_reg});
			wr(REG_FSR2, {4'h0, rows[i].fsr2});
			wr(REG_MEM_ADDR, {4'h0, rows[i].phys});
			wr(REG_MEM_DATA, {8'h00, rows[i].init});
			wr(REG_WREG, 16'h003C);
			wr(REG_STATUS, 16'h0000);
			wr(REG_INSTR, {OP_COMPLEMENT, rows[i].d, rows[i].a, rows[i].f});
			repeat (10) @(posedge clk);
			rd(REG_WREG, rv);
			chk(rv, {8'h00, rows[i].d ? 8'h3C : rows[i].res}, "wreg");
			rd(REG_MEM_DATA, rv);
			chk(rv, {8'h00, rows[i].d ? rows[i].res : rows[i].init}, "mem");
			rd(REG_STATUS, rv);
			chk(rv, {14'h0000, rows[i].res[7], rows[i].res == 8'h00}, "nz");
			$display("test row %0d done", i);
		end
		// long enough for one counter wrap, so the postscaler is nonzero
		repeat (1100) @(posedge clk);
		rd(REG_POST, rv);
		chk(rv, 16'h0001, "post before");
		chk({15'h0000, watchdog_counter == 8'h00}, 16'h0000, "wdt before");
		wr(REG_STATUS, 16'h0003);
		chk({15'h0000, timeout_flag}, 16'h0000, "to cleared");
		reg_addr <= REG_INSTR;
		reg_wdata <= OP_WDT_CLEAR;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		for (k = 0; k < 12 && timeout_flag !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (timeout_flag !== 1'b1) begin
			$display("MISMATCH %0t clear never took effect", $time);
			n_errors++;
			complete_run();
		end
		// counter moves again at the next Q4, so look in this cycle
		chk({8'h00, watchdog_counter}, 16'h0000, "wdt cleared");
		chk({15'h0000, power_down_flag}, 16'h0001, "pd set");
		@(posedge clk);
		rd(REG_POST, rv);
		chk(rv, 16'h0000, "post cleared");
		rd(REG_STATUS, rv);
		chk(rv, 16'h000F, "status");
		// two Q4 ticks have passed since the clear
		rd(REG_WDT, rv);
		chk(rv, 16'h0002, "wdt ticks after clear");
		rd(4'hC, rv);
		chk(rv, 16'h0000, "unmapped");
		$display("test watchdog clear done");
		// read data must fall back to zero after its one cycle
		rd(REG_CTRL, rv);
		chk(rv, 16'h0001, "ctrl idle");
		#1;
		chk(reg_rdata, 16'h0000, "rdata dropped");
		@(posedge clk);
		// an opcode outside both instructions must leave state alone
		wr(REG_WREG, 16'h005A);
		wr(REG_INSTR, 16'h0000);
		repeat (10) @(posedge clk);
		rd(REG_WREG, rv);
		chk(rv, 16'h005A, "nop wreg");
		rd(REG_INSTR, rv);
		chk(rv, 16'h0000, "nop executed");
		rd(REG_STATUS, rv);
		chk(rv, 16'h000F, "nop status");
		$display("test nop done");
		// bus writes every cycle across a core write-back: none may be lost
		wr(REG_BSR, 16'h0003);
		wr(REG_MEM_ADDR, 16'h0330);
		wr(REG_MEM_DATA, 16'h00C3);
		wr(REG_MEM_ADDR, 16'h0100);
		wr(REG_INSTR, {OP_COMPLEMENT, 1'b1, 1'b1, 8'h30});
		reg_addr <= REG_MEM_DATA;
		reg_wr <= 1'b1;
		for (k = 0; k < 8; k++) begin
			reg_wdata <= 16'(k);
			@(posedge clk);
		end
		reg_wr <= 1'b0;
		// the held bus write drains one slot after the last strobe
		repeat (2) @(posedge clk);
		rd(REG_MEM_DATA, rv);
		chk(rv, 16'h0007, "last bus write");
		wr(REG_MEM_ADDR, 16'h0330);
		rd(REG_MEM_DATA, rv);
		chk(rv, 16'h003C, "core write-back");
		rd(REG_STATUS, rv);
		chk(rv, 16'h000C, "collision flags");
		rd(REG_FSR2, rv);
		chk(rv, 16'h0200, "fsr2 readback");
		rd(REG_MEM_ADDR, rv);
		chk(rv, 16'h0330, "pointer readback");
		rd(REG_BSR, rv);
		chk(rv, 16'h0003, "bank readback");
		$display("test collision done");
		complete_run();
	end

endmodule
